//--- chbs_pkg.sv
// package of constants for the card host bus controller
package chbs_pkg;
  // operating modes of the card interface
  typedef enum logic [1:0] {
    CHBS_MODE_MEM  = 2'h0,
    CHBS_MODE_IO   = 2'h1,
    CHBS_MODE_IDE  = 2'h2
  } chbs_mode_t;
  // controller sequencer states
  typedef enum logic [2:0] {
    CHBS_IDLE   = 3'h0,
    CHBS_SETUP  = 3'h1,
    CHBS_STROBE = 3'h2,
    CHBS_HOLD   = 3'h3,
    CHBS_DMAWT  = 3'h4
  } chbs_state_t;
  // strobe timing in ns and derived cycles at 40 MHz
  localparam int CHBS_CLK_NS       = 25;
  localparam int CHBS_SETUP_NS     = 70;
  localparam int CHBS_STROBE_NS    = 165;
  localparam int CHBS_HOLD_NS      = 30;
  localparam int CHBS_SETUP_CYC    =
    (CHBS_SETUP_NS + CHBS_CLK_NS - 1) / CHBS_CLK_NS;
  localparam int CHBS_STROBE_CYC   =
    (CHBS_STROBE_NS + CHBS_CLK_NS - 1) / CHBS_CLK_NS;
  localparam int CHBS_HOLD_CYC     =
    (CHBS_HOLD_NS + CHBS_CLK_NS - 1) / CHBS_CLK_NS;
  // data bus geometry
  localparam int CHBS_BYTE_W       = 8;
  localparam int CHBS_WORD_W       = 16;
  localparam int CHBS_CNT_W        = 4;
  // reset values
  localparam logic [15:0] CHBS_DATA_RST = 16'h0000;
  localparam logic [3:0]  CHBS_CNT_RST  = 4'h0;
endpackage

//--- chbs_host_ctrl.sv
// host controller driving a flash card's parallel bus pins
// Functional notes
// - host ties role select low in card modes
// - bit 0 even byte, bit 8 odd byte
// - task file bytes on 7:0, data 16-bit; lanes 15:8 are masked in ide mode only, io and memory modes pass all 16 bits
// - host gates read buffers with acknowledge in io mode
// - read strobe to host, write strobe to card
// - request held until host acknowledges
// - chip selects negated, 16-bit during dma ack
`timescale 1ns/1ps
module chbs_host_ctrl
  import chbs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // user command side
  input  wire chbs_mode_t  mode,
  input  wire logic        roleMaster,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic        cmdWrite,
  input  wire logic        cmdTaskFile,
  input  wire logic        cmdAltStatus,
  input  wire logic [15:0] cmdWdata,
  input  wire logic        dmaEnable,
  input  wire logic        dmaWrite,
  output logic             rspValid,
  output logic [15:0]      rspRdata,
  output logic             rspAcked,
  // card pins
  output logic             drive_role_select_n,
  output logic             task_file_select_n,
  output logic             alt_status_select_n,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             dma_ack_n,
  input  wire logic [15:0] host_data_bus_in,
  output logic [15:0]      host_data_bus_out,
  output logic             host_data_bus_oe,
  input  wire logic        input_ack_n,
  input  wire logic        dma_request,
  // buffer enable toward the processor
  output logic             readBufEnable
);

  // synchronisers for card pins
  logic [15:0] dataMeta;                    // first stage, data
  logic [15:0] dataSync;                    // second stage, data
  logic        ackMeta;                     // first stage, acknowledge
  logic        ackSync;                     // second stage, acknowledge
  logic        dreqMeta;                    // first stage, dma request
  logic        dreqSync;                    // second stage, dma request

  // sequencer state
  chbs_state_t      state;                  // current state
  chbs_state_t      next_state;             // next state
  logic [3:0]       cnt;                    // phase counter
  logic [3:0]       next_cnt;               // next phase counter
  logic             isWrite;                // latched direction
  logic             next_isWrite;
  logic             isDma;                  // latched dma transfer
  logic             next_isDma;
  logic             selTf;                  // latched task file select
  logic             next_selTf;
  logic             selAlt;                 // latched alt status select
  logic             next_selAlt;
  logic [15:0]      wdata;                  // latched write data
  logic [15:0]      next_wdata;
  logic [15:0]      rdata;                  // captured read data
  logic [15:0]      next_rdata;
  logic             rvalid;                 // read data pulse
  logic             next_rvalid;
  logic             acked;                  // acknowledge seen in read
  logic             next_acked;

  // two flip-flop capture of asynchronous card outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dataMeta <= CHBS_DATA_RST;
      dataSync <= CHBS_DATA_RST;
      ackMeta  <= 1'b1;
      ackSync  <= 1'b1;
      dreqMeta <= 1'b0;
      dreqSync <= 1'b0;
    end else begin
      dataMeta <= host_data_bus_in;
      dataSync <= dataMeta;
      ackMeta  <= input_ack_n;
      ackSync  <= ackMeta;
      dreqMeta <= dma_request;
      dreqSync <= dreqMeta;
    end
  end

  // role pin: low selects master in ide, low always in card modes
  always_comb begin
    if (mode == CHBS_MODE_IDE) begin
      drive_role_select_n = !roleMaster;
    end else begin
      drive_role_select_n = 1'b0;
    end
  end

  // a dma cycle may start only when the card requests in ide mode
  logic dmaGo;
  assign dmaGo = dmaEnable && (mode == CHBS_MODE_IDE) && dreqSync;

  // sequencer next-state logic
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_isWrite = isWrite;
    next_isDma   = isDma;
    next_selTf   = selTf;
    next_selAlt  = selAlt;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    next_acked   = acked;
    case (state)
      CHBS_IDLE: begin
        // dma has priority over register commands
        if (dmaGo) begin
          next_isDma   = 1'b1;
          next_isWrite = dmaWrite;
          next_selTf   = 1'b0;
          next_selAlt  = 1'b0;
          next_wdata   = cmdWdata;
          next_acked   = 1'b0;
          next_cnt     = CHBS_CNT_RST;
          next_state   = CHBS_SETUP;
        end else if (cmdValid) begin
          next_isDma   = 1'b0;
          next_isWrite = cmdWrite;
          next_selTf   = cmdTaskFile;
          next_selAlt  = cmdAltStatus && !cmdTaskFile;
          // task file bytes only on low lanes in ide mode
          if (mode == CHBS_MODE_IDE && (cmdTaskFile || cmdAltStatus)) begin
            next_wdata = {8'h00, cmdWdata[7:0]};
          end else begin
            next_wdata = cmdWdata;
          end
          next_acked   = 1'b0;
          next_cnt     = CHBS_CNT_RST;
          next_state   = CHBS_SETUP;
        end
      end
      CHBS_SETUP: begin
        // address and select setup before strobe
        if (cnt == 4'(CHBS_SETUP_CYC - 1)) begin
          next_cnt   = CHBS_CNT_RST;
          next_state = CHBS_STROBE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      CHBS_STROBE: begin
        // strobe active; acknowledge only counts in io mode
        if (!ackSync && mode == CHBS_MODE_IO && !isWrite) begin
          next_acked = 1'b1;
        end
        if (cnt == 4'(CHBS_STROBE_CYC - 1)) begin
          next_cnt   = CHBS_CNT_RST;
          // register bytes come back on the low lanes only in ide mode
          if (mode == CHBS_MODE_IDE && (selTf || selAlt)) begin
            next_rdata = {8'h00, dataSync[7:0]};
          end else begin
            next_rdata = dataSync;
          end
          next_state = CHBS_HOLD;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      CHBS_HOLD: begin
        // recovery after strobe release
        if (cnt == 4'(CHBS_HOLD_CYC - 1)) begin
          next_cnt    = CHBS_CNT_RST;
          next_rvalid = !isWrite;
          next_state  = isDma ? CHBS_DMAWT : CHBS_IDLE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      CHBS_DMAWT: begin
        // keep ack until synchronised request has had time to drop
        if (cnt == 4'h2) begin
          next_cnt   = CHBS_CNT_RST;
          next_isDma = 1'b0;
          next_state = CHBS_IDLE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      default: begin
        next_state = CHBS_IDLE;
        next_cnt   = CHBS_CNT_RST;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state   <= CHBS_IDLE;
      cnt     <= CHBS_CNT_RST;
      isWrite <= 1'b0;
      isDma   <= 1'b0;
      selTf   <= 1'b0;
      selAlt  <= 1'b0;
      wdata   <= CHBS_DATA_RST;
      rdata   <= CHBS_DATA_RST;
      rvalid  <= 1'b0;
      acked   <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      isWrite <= next_isWrite;
      isDma   <= next_isDma;
      selTf   <= next_selTf;
      selAlt  <= next_selAlt;
      wdata   <= next_wdata;
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
      acked   <= next_acked;
    end
  end

  // pin drive derived from state
  logic active;
  assign active = (state != CHBS_IDLE) && (state != CHBS_DMAWT);
  assign cmdReady = (state == CHBS_IDLE) && !dmaGo;
  // chip selects stay negated through dma
  assign task_file_select_n  = !(active && selTf && !isDma);
  assign alt_status_select_n = !(active && selAlt && !isDma);
  assign dma_ack_n           = !isDma;
  assign io_read_strobe_n    = !(state == CHBS_STROBE && !isWrite);
  assign io_write_strobe_n   = !(state == CHBS_STROBE && isWrite);
  assign host_data_bus_out   = wdata;
  assign host_data_bus_oe    = active && isWrite;
  // read buffers follow the card's acknowledge in io mode
  assign readBufEnable = (mode == CHBS_MODE_IO) && !isWrite &&
                         (state == CHBS_STROBE) && !ackSync;
  assign rspValid = rvalid;
  assign rspRdata = rdata;
  assign rspAcked = acked;

  // assertions
  a_dma_cs_negated: assert property (@(posedge mclk) disable iff (!nrst)
    !dma_ack_n |-> task_file_select_n && alt_status_select_n)
    else $error("chip select during dma acknowledge");
  a_strobe_excl: assert property (@(posedge mclk) disable iff (!nrst)
    !(!io_read_strobe_n && !io_write_strobe_n))
    else $error("both strobes asserted");
  a_strobe_len: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(io_read_strobe_n) |-> !io_read_strobe_n [*7] ##1
    io_read_strobe_n)
    else $error("read strobe width wrong");
  a_dma_dir: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dma_ack_n) |-> isWrite == $past(dmaWrite))
    else $error("dma direction differs from requested direction");
  a_role_pin: assert property (@(posedge mclk) disable iff (!nrst)
    (mode != CHBS_MODE_IDE) |-> !drive_role_select_n)
    else $error("role select not grounded in card mode");
  a_role_ide: assert property (@(posedge mclk) disable iff (!nrst)
    (mode == CHBS_MODE_IDE) |-> drive_role_select_n == !roleMaster)
    else $error("role select wrong in ide mode");
  a_ack_mem: assert property (@(posedge mclk) disable iff (!nrst)
    (mode == CHBS_MODE_MEM) |-> !readBufEnable)
    else $error("buffer enabled in memory mode");
  a_dma_ack_len: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dma_ack_n) |-> !dma_ack_n [*8])
    else $error("dma acknowledge dropped early");
  a_tf_lanes: assert property (@(posedge mclk) disable iff (!nrst)
    (host_data_bus_oe && !task_file_select_n && mode == CHBS_MODE_IDE)
    |-> host_data_bus_out[15:8] == 8'h00)
    else $error("task file write on high lanes");

endmodule

//--- chbs_card_model.sv
// behavioural flash card answering the host controller pins
`timescale 1ns/1ps
module chbs_card_model
  import chbs_pkg::*;
(
  // bench configuration
  input  wire chbs_mode_t  mode,
  input  wire logic        targetMaster,
  // host pins
  input  wire logic        drive_role_select_n,
  input  wire logic        task_file_select_n,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic        dma_ack_n,
  input  wire logic [15:0] host_data_bus_out,
  // card pins
  output logic [15:0]      cardData,
  output logic             input_ack_n,
  output wire              dma_request
);
  logic [15:0] mem = 16'h0000;     // word last written by the host
  logic [15:0] lastOut = 16'h0000; // last word the card drove
  logic [3:0]  pending = 4'h0;     // dma words still to move
  logic        acked = 1'b0;       // host acknowledged this request
  logic        wrOn = 1'b0;        // write strobe seen low
  logic        isMaster;           // role taken from the pin
  logic        reading;            // card owns the bus
  logic [15:0] dataOut;            // word the card would drive
  // an open pin reads high through the internal pull-up
  assign isMaster = (drive_role_select_n === 1'b0);
  assign reading = (io_read_strobe_n === 1'b0) && (mode != CHBS_MODE_MEM);
  // task file bytes on the low lanes, junk on the upper lanes
  assign dataOut = (task_file_select_n === 1'b0) ?
    {8'hA5, mem[7:0]} : mem;
  // a released bus shows the inverse of the last word
  assign cardData = reading ? dataOut : ~lastOut;
  // acknowledge only io reads in io mode
  assign input_ack_n = !(reading && mode == CHBS_MODE_IO);
  // request only while selected, held until acknowledged
  assign dma_request = (mode == CHBS_MODE_IDE && isMaster == targetMaster)
    ? (pending != 4'h0 && !acked) : 1'bz;
  // remember the driven word for the release pattern
  always @(posedge io_read_strobe_n) lastOut = dataOut;
  // write data latched on the trailing edge of the strobe
  // clockless card: strobes act at their own edges, no sync stage
  always @(negedge io_write_strobe_n) wrOn = 1'b1;
  always @(posedge io_write_strobe_n) begin
    if (wrOn && mode != CHBS_MODE_MEM) mem = host_data_bus_out;
    wrOn = 1'b0;
  end
  // each strobe under acknowledge moves one dma word
  always @(posedge io_read_strobe_n or posedge io_write_strobe_n) begin
    if (dma_ack_n === 1'b0 && pending != 4'h0) pending = pending - 4'h1;
  end
  // acknowledge drops the request, release may raise it again
  always @(dma_ack_n) acked = (dma_ack_n === 1'b0);
endmodule

//--- tb_chbs_host_ctrl.sv
// self-checking bench for the card host bus controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_chbs_host_ctrl
  import chbs_pkg::*;
;
  logic mclk = 0, nrst = 0, roleMaster = 1, cmdValid = 0, cmdWrite = 0;
  logic cmdTaskFile = 0, dmaEnable = 0, dmaWrite = 0, targetMaster = 1;
  logic sawBuf = 0, sawAlt = 0, cmdAltStatus = 0;
  chbs_mode_t mode = CHBS_MODE_IDE;
  logic [15:0] cmdWdata = 16'h0000, got, busOut, cardData;
  logic cmdReady, rspValid, rspAcked, roleN, tfN, asN, rdN, wrN, ackN, oe;
  logic inAckN, readBufEnable;
  logic [15:0] rspRdata;
  wire dmaReq;
  wire [15:0] busIn = oe ? busOut : cardData;
  int mismatches = 0, check_count = 0, rspCount = 0;
  pulldown (dmaReq);
  always #12.5 mclk = ~mclk;
  chbs_host_ctrl dut (.mclk(mclk), .nrst(nrst), .mode(mode),
    .roleMaster(roleMaster), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdWrite(cmdWrite), .cmdTaskFile(cmdTaskFile),
    .cmdAltStatus(cmdAltStatus),
    .cmdWdata(cmdWdata), .dmaEnable(dmaEnable), .dmaWrite(dmaWrite),
    .rspValid(rspValid), .rspRdata(rspRdata), .rspAcked(rspAcked),
    .drive_role_select_n(roleN), .task_file_select_n(tfN),
    .alt_status_select_n(asN), .io_read_strobe_n(rdN),
    .io_write_strobe_n(wrN), .dma_ack_n(ackN), .host_data_bus_in(busIn),
    .host_data_bus_out(busOut), .host_data_bus_oe(oe),
    .input_ack_n(inAckN), .dma_request(dmaReq),
    .readBufEnable(readBufEnable));
  chbs_card_model card (.mode(mode), .targetMaster(targetMaster),
    .drive_role_select_n(roleN), .task_file_select_n(tfN),
    .io_read_strobe_n(rdN), .io_write_strobe_n(wrN), .dma_ack_n(ackN),
    .host_data_bus_out(busOut), .cardData(cardData),
    .input_ack_n(inAckN), .dma_request(dmaReq));
  // collect answers and watch selects under dma acknowledge
  always @(negedge mclk) begin
    if (rspValid === 1'b1) begin
      got = rspRdata;
      rspCount++;
    end
    if (readBufEnable === 1'b1) sawBuf = 1'b1;
    if (asN === 1'b0) sawAlt = 1'b1;
    if (nrst && ackN === 1'b0) `CHK({tfN, asN}, 2'b11)
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bounded waits, a spent bound ends the run
  task automatic waitUntil(input int kind, input int want);
    int n;
    n = 0;
    while (!(kind == 0 ? cmdReady === 1'b1 : kind == 1 ? rspCount >= want
      : card.pending == 4'h0) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      $display("mismatch at %0t: wait bound spent", $time);
      conclude();
    end
  endtask
  // one register access through the command port
  task automatic access(input logic w, input logic tf, input logic [15:0] d);
    int start;
    start = rspCount;
    waitUntil(0, 0);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdTaskFile = tf;
    cmdWdata = d;
    @(negedge mclk);
    cmdValid = 1'b0;
    if (!w) waitUntil(1, start + 1);
    waitUntil(0, 0);
  endtask
  task automatic t_role();
    `CHK(roleN, 1'b0)
    roleMaster = 1'b0;
    @(negedge mclk);
    `CHK(roleN, 1'b1)
    mode = CHBS_MODE_MEM;
    @(negedge mclk);
    `CHK(roleN, 1'b0)
    mode = CHBS_MODE_IDE;
    roleMaster = 1'b1;
    @(negedge mclk);
    `CHK({rdN, wrN, ackN, oe}, 4'hE)
    $display("role test done");
  endtask
  task automatic t_lanes();
    access(1'b1, 1'b1, 16'hBEEF);
    `CHK(card.mem, 16'h00EF)
    access(1'b0, 1'b1, 16'h0000);
    `CHK(got, 16'h00EF)
    access(1'b1, 1'b0, 16'h1234);
    `CHK(card.mem[7:0], 8'h34)
    `CHK(card.mem[15:8], 8'h12)
    access(1'b0, 1'b0, 16'h0000);
    `CHK(got, 16'h1234)
    cmdAltStatus = 1'b1;
    access(1'b0, 1'b0, 16'h0000);
    cmdAltStatus = 1'b0;
    `CHK(got, 16'h0034)
    `CHK(sawAlt, 1'b1)
    $display("lane test done");
  endtask
  task automatic t_ack();
    mode = CHBS_MODE_IO;
    sawBuf = 1'b0;
    access(1'b0, 1'b0, 16'h0000);
    `CHK(rspAcked, 1'b1)
    `CHK(sawBuf, 1'b1)
    mode = CHBS_MODE_MEM;
    sawBuf = 1'b0;
    access(1'b0, 1'b0, 16'h0000);
    `CHK(rspAcked, 1'b0)
    `CHK(sawBuf, 1'b0)
    mode = CHBS_MODE_IDE;
    $display("acknowledge test done");
  endtask
  task automatic t_dma();
    int start;
    start = rspCount;
    card.pending = 4'h2;
    dmaEnable = 1'b1;
    waitUntil(1, start + 2);
    `CHK(got, 16'h1234)
    repeat (40) @(negedge mclk);
    `CHK(rspCount - start, 2)
    dmaWrite = 1'b1;
    cmdWdata = 16'hC3A5;
    card.pending = 4'h1;
    waitUntil(2, 0);
    waitUntil(0, 0);
    `CHK(card.mem, 16'hC3A5)
    targetMaster = 1'b0;
    card.pending = 4'h1;
    repeat (40) @(negedge mclk);
    `CHK(dmaReq, 1'b0)
    `CHK(card.pending, 4'h1)
    dmaEnable = 1'b0;
    $display("dma test done");
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    t_role();
    t_lanes();
    t_ack();
    t_dma();
    conclude();
  end
endmodule
